// ===== include/cmp_match_pkg.sv
// constants for the debug comparator match block
// assumes an apb slave with 32-bit data and a 40 mhz pclk
package cmp_match_pkg;
  // ----------------------------------------
  // register indices, byte address is index * 4
  // ----------------------------------------
  localparam logic [7:0] IDX_CTL = 8'h28;
  localparam logic [7:0] IDX_AH = 8'h29;
  localparam logic [7:0] IDX_AM = 8'h2a;
  localparam logic [7:0] IDX_AL = 8'h2b;
  localparam logic [7:0] IDX_DH = 8'h2c;
  localparam logic [7:0] IDX_DL = 8'h2d;
  localparam logic [7:0] IDX_DHM = 8'h2e;
  localparam logic [7:0] IDX_DLM = 8'h2f;
  localparam logic [7:0] IDX_DC1 = 8'h30;
  localparam logic [7:0] IDX_IST = 8'h31;
  localparam logic [7:0] IDX_IMSK = 8'h32;
  localparam int ADDR_W = 10;
  // ----------------------------------------
  // control bit positions
  // ----------------------------------------
  localparam int B_SZE = 7;
  localparam int B_SZ = 6;
  localparam int B_TAG = 5;
  localparam int B_BRK = 4;
  localparam int B_RW = 3;
  localparam int B_RWE = 2;
  localparam int B_NDB = 1;
  localparam int B_EN = 0;
  // debug_control_one: [1:0] window_select, 4 global_breakpoint_enable, 7 arm
  localparam int B_ARM = 7;
  localparam int B_GBRK = 4;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] CTL_MASK_A = 8'hff;
  localparam logic [7:0] CTL_MASK_B = 8'hfd;
  localparam logic [7:0] CTL_MASK_C = 8'h3d;
  localparam logic [7:0] DC1_MASK = 8'h93;
  localparam int NCMP = 3;
  localparam int AW = 18;
  localparam int NEV = 4;
endpackage : cmp_match_pkg

// ===== src/cmp_channel.sv
// one comparator channel: untagged match test against the bus
// assumes bus signals synchronous to pclk
module cmp_channel #(
  parameter int AW = 18,
  parameter bit HAS_DATA = 1'b0
) (
  input wire logic [7:0] ctl,
  input wire logic [AW-1:0] ref_addr,
  input wire logic [15:0] ref_data,
  input wire logic [15:0] ref_mask,
  input wire logic [AW-1:0] bus_addr,
  input wire logic [15:0] bus_data,
  input wire logic bus_byte,
  input wire logic bus_read,
  input wire logic bus_valid,
  output logic hit
);
  import cmp_match_pkg::*;
  logic addr_ok, size_ok, dir_ok, data_ok, data_eq;
  // each enabled criterion must hold in the same cycle
  always_comb begin
    addr_ok = (bus_addr == ref_addr); // R13 R15
    size_ok = !ctl[B_SZE] || (ctl[B_SZ] == bus_byte); // R3 R4
    dir_ok = !ctl[B_RWE] || (ctl[B_RW] == bus_read); // R8
    data_eq = ((bus_data ^ ref_data) & ref_mask) == 16'h0000; // R17
    data_ok = !HAS_DATA || (data_eq ^ ctl[B_NDB]); // R10 R16
    hit = ctl[B_EN] && bus_valid && addr_ok && size_ok && dir_ok && data_ok; // R11 R18
  end
endmodule : cmp_channel

// ===== src/tag_tracker.sv
// tag tracker: remembers a tagged opcode fetch until re-arm or disable, also after it executes
// assumes fetch address and execute address come from the pipeline
module tag_tracker #(
  parameter int AW = 18
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic arm_start,
  input wire logic enable,
  input wire logic [AW-1:0] ref_addr,
  input wire logic fetch_valid,
  input wire logic [AW-1:0] fetch_addr,
  input wire logic exec_valid,
  input wire logic [AW-1:0] exec_addr,
  output logic fire
);
  logic pend_q;
  // tag set on fetch match, fires when that opcode executes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
    end else if (arm_start || !enable) begin
      pend_q <= 1'b0;
    end else if (fetch_valid && fetch_addr == ref_addr) begin
      pend_q <= 1'b1;
    end
  end
  assign fire = enable && pend_q && exec_valid && exec_addr == ref_addr;
endmodule : tag_tracker

// ===== src/cmp_match.sv
// comparator match block of the debug unit with its apb register window
// assumes apb master on pclk, bus and pipeline signals synchronous to pclk
// Summary of operation
// R1 - control slot reads comparator a, b or c by window select 00/01/10
// R2 - control writes ignored while the debug unit is armed
// R3 - bit 7 enables size comparison on a and b, ignored when tagging
// R4 - bit 6 picks word (0) or byte (1), ignored if disabled or tagging
// R5 - bit 5 clear: immediate transition; set: transition when tagged opcode executes
// R6 - bit 4 set: match ends session at once, disarms, stops trace
// R7 - immediate breakpoint only when global breakpoint enable is set
// R8 - bit 2 enables direction check; bit 3 zero writes, one reads
// R9 - direction bits ignored while tagging
// R10 - comparator a bit 1 inverts the data criterion, ignored while tagging
// R11 - bit 0 enables the comparator; disabled gives no match
// R12 - window select maps a, b, c address registers; 11 shows none
// R13 - address high bits 1:0 give expected address bits 17 and 16
// R14 - address high always readable, written only when not armed
// R15 - address mid and low give bits 15:0, eighteen bits compared
// R16 - comparator a compares data only when its tag bit is clear
// R17 - data bit compared only where its mask bit is one
// R18 - untagged match needs all enabled criteria in one bus cycle
//
// The APB interface to the registers was chosen for this implementation.
module cmp_match (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cmp_match_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [cmp_match_pkg::AW-1:0] bus_addr,
  input wire logic [15:0] bus_data,
  input wire logic bus_byte,
  input wire logic bus_read,
  input wire logic bus_valid,
  input wire logic exec_valid,
  input wire logic [cmp_match_pkg::AW-1:0] exec_addr,
  output logic [2:0] seq_match,
  output logic breakpoint,
  output logic trace_stop,
  output logic armed,
  output logic irq
);
  import cmp_match_pkg::*;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0] ctl_q [NCMP];
  logic [AW-1:0] addr_q [NCMP];
  logic [15:0] data_q, mask_q;
  logic [7:0] dc1_q;
  logic [NEV-1:0] ist_q, imsk_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic [2:0] seq_q;
  logic brk_q, tstop_q, irq_q;

  logic [1:0] wsel;
  logic arm_q, arm_start;
  logic acc, wr, rd;
  logic [7:0] wb;
  logic [NCMP-1:0] raw_hit, tag_hit, chan_hit;
  logic [7:0] ctl_sel;
  logic [AW-1:0] addr_sel;
  logic term;
  logic [NEV-1:0] ev;

  assign wsel = dc1_q[1:0];
  assign arm_q = dc1_q[B_ARM];
  assign wb = pwdata[7:0];
  // one-cycle answer: access phase is taken when pready is high
  assign acc = psel && penable && pready_q;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;

  // byte index decode, word aligned
  function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] a);
    reg_idx = a[ADDR_W-1:2];
  endfunction : reg_idx

  function automatic logic [7:0] ctl_mask(input int i);
    ctl_mask = (i == 0) ? CTL_MASK_A : ((i == 1) ? CTL_MASK_B : CTL_MASK_C);
  endfunction : ctl_mask

  // ----------------------------------------
  // comparator channels
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCMP; g++) begin : gen_ch
      cmp_channel #(.AW(AW), .HAS_DATA(g == 0)) u_ch (
        .ctl(ctl_q[g]),
        .ref_addr(addr_q[g]),
        .ref_data(data_q),
        .ref_mask(mask_q),
        .bus_addr(bus_addr),
        .bus_data(bus_data),
        .bus_byte(bus_byte),
        .bus_read(bus_read),
        .bus_valid(bus_valid),
        .hit(raw_hit[g])
      );
      tag_tracker #(.AW(AW)) u_tag (
        .pclk(pclk),
        .presetn(presetn),
        .arm_start(arm_start),
        .enable(arm_q && ctl_q[g][B_EN] && ctl_q[g][B_TAG]),
        .ref_addr(addr_q[g]),
        .fetch_valid(bus_valid && bus_read),
        .fetch_addr(bus_addr),
        .exec_valid(exec_valid),
        .exec_addr(exec_addr),
        .fire(tag_hit[g])
      );
      // tagged channel ignores size, direction and data
      assign chan_hit[g] = arm_q && (ctl_q[g][B_TAG] ? tag_hit[g] : raw_hit[g]); // R5 R9
    end
  endgenerate

  // session end on any match with immediate_session_end set
  always_comb begin
    term = 1'b0;
    for (int i = 0; i < NCMP; i++) begin
      term = term | (chan_hit[i] && ctl_q[i][B_BRK]); // R6
    end
  end

  // ----------------------------------------
  // apb register writes
  // ----------------------------------------
  assign arm_start = wr && reg_idx(paddr) == IDX_DC1 && wb[B_ARM] && !arm_q;

  // comparator control and address registers, locked while armed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCMP; i++) begin
        ctl_q[i] <= CTL_RST;
        addr_q[i] <= '0;
      end
      data_q <= 16'h0000;
      mask_q <= 16'h0000;
    end else if (wr && !arm_q && wsel != 2'b11) begin // R2 R14
      case (reg_idx(paddr))
        IDX_CTL: ctl_q[wsel] <= wb & ctl_mask(int'(wsel)); // R2
        IDX_AH: addr_q[wsel][17:16] <= wb[1:0]; // R13 R14
        IDX_AM: addr_q[wsel][15:8] <= wb; // R15
        IDX_AL: addr_q[wsel][7:0] <= wb; // R15
        IDX_DH: if (wsel == 2'b00) data_q[15:8] <= wb;
        IDX_DL: if (wsel == 2'b00) data_q[7:0] <= wb;
        IDX_DHM: if (wsel == 2'b00) mask_q[15:8] <= wb;
        IDX_DLM: if (wsel == 2'b00) mask_q[7:0] <= wb;
        default: ;
      endcase
    end
  end

  // debug_control_one: session end clears arm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc1_q <= 8'h00;
    end else begin
      if (wr && reg_idx(paddr) == IDX_DC1) begin
        dc1_q <= wb & DC1_MASK;
      end
      if (term) begin
        dc1_q[B_ARM] <= 1'b0; // R6
      end
    end
  end

  // ----------------------------------------
  // session outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= 3'b000;
      brk_q <= 1'b0;
      tstop_q <= 1'b0;
    end else begin
      seq_q <= chan_hit; // R5
      brk_q <= term && dc1_q[B_GBRK]; // R6 R7
      tstop_q <= term; // R6
    end
  end

  // ----------------------------------------
  // interrupts: per channel match and session end
  // ----------------------------------------
  assign ev = {term, chan_hit};

  // sticky status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= '0;
      imsk_q <= '0;
    end else begin
      if (wr && reg_idx(paddr) == IDX_IMSK) begin
        imsk_q <= wb[NEV-1:0];
      end
      if (wr && reg_idx(paddr) == IDX_IST) begin
        ist_q <= (ist_q & ~wb[NEV-1:0]) | ev;
      end else begin
        ist_q <= ist_q | ev;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ist_q & imsk_q);
    end
  end

  // ----------------------------------------
  // apb read path
  // ----------------------------------------
  always_comb begin
    ctl_sel = (wsel == 2'b11) ? 8'h00 : ctl_q[wsel]; // R1
    addr_sel = (wsel == 2'b11) ? '0 : addr_q[wsel]; // R12
  end

  // read data and no wait state per access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && !penable;
      pslverr_q <= 1'b0;
      if (psel && !penable) begin
        prdata_q <= 32'h0000_0000;
        pslverr_q <= (paddr[1:0] != 2'b00) || (reg_idx(paddr) < IDX_CTL) ||
                     (reg_idx(paddr) > IDX_IMSK);
        case (reg_idx(paddr))
          IDX_CTL: prdata_q[7:0] <= ctl_sel; // R1
          IDX_AH: prdata_q[1:0] <= addr_sel[17:16]; // R12 R14
          IDX_AM: prdata_q[7:0] <= addr_sel[15:8];
          IDX_AL: prdata_q[7:0] <= addr_sel[7:0];
          IDX_DH: if (wsel == 2'b00) prdata_q[7:0] <= data_q[15:8];
          IDX_DL: if (wsel == 2'b00) prdata_q[7:0] <= data_q[7:0];
          IDX_DHM: if (wsel == 2'b00) prdata_q[7:0] <= mask_q[15:8];
          IDX_DLM: if (wsel == 2'b00) prdata_q[7:0] <= mask_q[7:0];
          IDX_DC1: prdata_q[7:0] <= dc1_q;
          IDX_IST: prdata_q[NEV-1:0] <= ist_q;
          IDX_IMSK: prdata_q[NEV-1:0] <= imsk_q;
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign seq_match = seq_q;
  assign breakpoint = brk_q;
  assign trace_stop = tstop_q;
  assign armed = arm_q;
  assign irq = irq_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // named sequences
  // ----------------------------------------
  // a read of the bus at the reference address of tagged comparator a
  sequence tag_fetch_s;
    arm_q && ctl_q[0][B_EN] && ctl_q[0][B_TAG] && bus_valid && bus_read
    && bus_addr == addr_q[0];
  endsequence
  // no re-arm while the tagged opcode waits in the queue
  sequence tag_wait_s;
    !arm_start [*4];
  endsequence
  // the tagged opcode reaches execution on the same comparator
  sequence tag_exec_s;
    arm_q && ctl_q[0][B_EN] && ctl_q[0][B_TAG] && exec_valid && exec_addr == addr_q[0];
  endsequence
  // a channel with immediate_session_end matches while breakpoints are on
  sequence brk_match_s;
    term && dc1_q[B_GBRK];
  endsequence

  // register locks while armed
  ctl_lock_a: assert property (arm_q && wr && reg_idx(paddr) == IDX_CTL // R2
    |=> ctl_q[0] == $past(ctl_q[0]) && ctl_q[1] == $past(ctl_q[1])
    && ctl_q[2] == $past(ctl_q[2])) else $error("control written while armed");
  ah_lock_a: assert property (arm_q && wr // R14
    |=> addr_q[0] == $past(addr_q[0]) && addr_q[1] == $past(addr_q[1])
    && addr_q[2] == $past(addr_q[2])) else $error("address written while armed");

  // match criteria of comparator a
  off_nomatch_a: assert property (!ctl_q[0][B_EN] |-> !raw_hit[0]) // R11
    else $error("disabled comparator matched");
  dir_qual_a: assert property (ctl_q[0][B_RWE] && (ctl_q[0][B_RW] != bus_read) // R8
    |-> !raw_hit[0]) else $error("direction mismatch matched");
  size_qual_a: assert property (ctl_q[0][B_SZE] && (ctl_q[0][B_SZ] != bus_byte) // R3 R4
    |-> !raw_hit[0]) else $error("size mismatch matched");
  data_mask_a: assert property (mask_q[15:8] == 8'h00 && !ctl_q[0][B_NDB] // R17 R10
    && bus_data[7:0] == data_q[7:0] && ctl_q[0][B_EN] && bus_valid
    && bus_addr == addr_q[0] && !ctl_q[0][B_SZE] && !ctl_q[0][B_RWE] |-> raw_hit[0])
    else $error("masked data blocked match");

  // session end and breakpoints
  brk_gate_a: assert property (breakpoint |-> $past(dc1_q[B_GBRK]) && trace_stop) // R7
    else $error("breakpoint without global enable");
  brk_off_a: assert property (term && !dc1_q[B_GBRK] |=> !breakpoint) // R7
    else $error("breakpoint while globally disabled");
  brk_fire_a: assert property (brk_match_s |=> breakpoint && trace_stop && !armed) // R6 R7
    else $error("breakpoint not produced");
  session_end_a: assert property (term |=> !armed && trace_stop) // R6
    else $error("session not ended");

  // tagging and sequencer pulses
  tag_hold_a: assert property (ctl_q[0][B_TAG] // R5 R9
    && !(exec_valid && exec_addr == addr_q[0]) |=> !seq_match[0])
    else $error("tagged channel matched without execution");
  tag_fire_a: assert property (tag_fetch_s ##1 tag_wait_s ##0 tag_exec_s |=> seq_match[0]) // R5
    else $error("tagged opcode executed without match");
  idle_quiet_a: assert property (!arm_q |=> seq_match == 3'b000) // R5
    else $error("match while not armed");

  // register bus and interrupts
  rd_sel_a: assert property (psel && !penable && !pwrite && reg_idx(paddr) == IDX_CTL // R1
    && wsel == 2'b01 |=> prdata[7:0] == $past(ctl_q[1])) else $error("bad read");
  win_none_a: assert property (psel && !penable && wsel == 2'b11 // R12
    && reg_idx(paddr) >= IDX_CTL && reg_idx(paddr) <= IDX_DLM |=> prdata == 32'h0000_0000)
    else $error("window select none showed a register");
  ready_next_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held beyond one cycle");
  irq_level_a: assert property (|(ist_q & imsk_q) |=> irq)
    else $error("unmasked status without interrupt");
  stat_set_a: assert property (chan_hit[0] |=> ist_q[0])
    else $error("match not recorded in status");
endmodule : cmp_match

// ===== verification/cpu_bus_model.sv
// processor bus and instruction pipeline model facing the comparators
// assumes the block samples every bus signal on rising pclk
module cpu_bus_model (
  input wire logic pclk,
  output logic [cmp_match_pkg::AW-1:0] bus_addr,
  output logic [15:0] bus_data,
  output logic bus_byte,
  output logic bus_read,
  output logic bus_valid,
  output logic exec_valid,
  output logic [cmp_match_pkg::AW-1:0] exec_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  import cmp_match_pkg::*;
  // ------------------------------
  // idle bus at time zero
  // ------------------------------
  initial begin
    bus_addr = '0;
    bus_data = '0;
    bus_byte = 1'b0;
    bus_read = 1'b0;
    bus_valid = 1'b0;
    exec_valid = 1'b0;
    exec_addr = '0;
  end
  // one bus cycle; released lines show the inverse, not stale values
  task automatic access(input logic [AW-1:0] a, input logic [15:0] d,
                        input logic b, input logic r);
    @(posedge pclk);
    bus_addr <= a;
    bus_data <= d;
    bus_byte <= b;
    bus_read <= r;
    bus_valid <= 1'b1;
    @(posedge pclk);
    bus_addr <= ~a;
    bus_data <= ~d;
    bus_byte <= ~b;
    bus_read <= ~r;
    bus_valid <= 1'b0;
  endtask : access
  // one opcode reaching execution
  task automatic execute(input logic [AW-1:0] a);
    @(posedge pclk);
    exec_addr <= a;
    exec_valid <= 1'b1;
    @(posedge pclk);
    exec_addr <= ~a;
    exec_valid <= 1'b0;
  endtask : execute
endmodule : cpu_bus_model

// ===== verification/test_cmp_match.sv
// self-checking bench for the comparator match block
// assumes cpu_bus_model and the design files are compiled first
module test_cmp_match;
  timeunit 1ns;
  timeprecision 1ps;
  import cmp_match_pkg::*;
  localparam logic [AW-1:0] HIT = 18'h12345;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err;
  logic [AW-1:0] bus_addr, exec_addr;
  logic [15:0] bus_data;
  logic bus_byte, bus_read, bus_valid, exec_valid;
  logic [2:0] seq_match;
  logic breakpoint, trace_stop, armed, irq;
  int mismatches = 0;
  int cmp_count = 0;
  logic [7:0] msk [3] = '{CTL_MASK_A, CTL_MASK_B, CTL_MASK_C};
  // ctl, bus data, byte, read, expected match
  logic [26:0] cs [12] = '{{8'h01, 16'h005a, 3'b011}, {8'h01, 16'h0011, 3'b010},
    {8'h03, 16'h0011, 3'b011}, {8'h00, 16'h005a, 3'b010}, {8'h0d, 16'h005a, 3'b011},
    {8'h0d, 16'h005a, 3'b000}, {8'h09, 16'h005a, 3'b001}, {8'h81, 16'h005a, 3'b011},
    {8'h81, 16'h005a, 3'b110}, {8'hc1, 16'h005a, 3'b111}, {8'h25, 16'h005a, 3'b010},
    {8'h01, 16'hff5a, 3'b011}};
  // 40 mhz clock
  always #12.5 pclk = ~pclk;
  cmp_match dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_addr(bus_addr), .bus_data(bus_data),
    .bus_byte(bus_byte), .bus_read(bus_read), .bus_valid(bus_valid),
    .exec_valid(exec_valid), .exec_addr(exec_addr), .seq_match(seq_match),
    .breakpoint(breakpoint), .trace_stop(trace_stop), .armed(armed), .irq(irq));
  cpu_bus_model pm (.pclk(pclk), .bus_addr(bus_addr), .bus_data(bus_data),
    .bus_byte(bus_byte), .bus_read(bus_read), .bus_valid(bus_valid),
    .exec_valid(exec_valid), .exec_addr(exec_addr));
  // ------------------------------
  // checking and closing
  // ------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  // ------------------------------
  // apb master: setup, access until pready
  // ------------------------------
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rdchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    check(name, rd, {24'h0, exp});
  endtask : rdchk
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge pclk);
    #1;
    check("irq", 32'(irq), 32'(exp));
  endtask : irq_is
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      wr(IDX_DC1, 8'(s));
      wr(IDX_CTL, 8'hff);
      rdchk("ctl", IDX_CTL, msk[s]);
      wr(IDX_CTL, 8'h00);
      wr(IDX_AH, 8'(s + 1));
      rdchk("addr high", IDX_AH, 8'(s + 1));
    end
    wr(IDX_DC1, 8'h03);
    rdchk("addr high none", IDX_AH, 8'h00);
    wr(IDX_AH, 8'h00);
    wr(IDX_DC1, 8'h80);
    wr(IDX_CTL, 8'h55);
    wr(IDX_AH, 8'h03);
    wr(IDX_DC1, 8'h00);
    rdchk("ctl kept", IDX_CTL, 8'h00);
    rdchk("addr high kept", IDX_AH, 8'h01);
    apb(1'b0, 8'h3f, 8'h00);
    check("slverr", 32'(err), 32'h1);
    $display("test registers done");
    wr(IDX_AM, 8'h23);
    wr(IDX_AL, 8'h45);
    wr(IDX_DL, 8'h5a);
    wr(IDX_DLM, 8'hff);
    foreach (cs[i]) begin
      wr(IDX_DC1, 8'h00);
      wr(IDX_CTL, cs[i][26:19]);
      wr(IDX_DC1, 8'h80);
      pm.access(HIT, cs[i][18:3], cs[i][2], cs[i][1]);
      #1;
      check("match a", 32'(seq_match), 32'(cs[i][0]));
    end
    $display("test criteria done");
    wr(IDX_DC1, 8'h00);
    wr(IDX_CTL, 8'h21);
    wr(IDX_DC1, 8'h80);
    pm.access(HIT, 16'h0000, 1'b0, 1'b1);
    #1;
    check("tag fetch", 32'(seq_match), 32'h0);
    pm.execute(HIT ^ 18'h1);
    #1;
    check("tag other", 32'(seq_match), 32'h0);
    pm.execute(HIT);
    #1;
    check("tag exec", 32'(seq_match), 32'h1);
    $display("test tag done");
    wr(IDX_IMSK, 8'h00);
    irq_is(1'b0);
    rdchk("status", IDX_IST, 8'h01);
    wr(IDX_IMSK, 8'h01);
    irq_is(1'b1);
    wr(IDX_IST, 8'h0f);
    irq_is(1'b0);
    rdchk("status clear", IDX_IST, 8'h00);
    $display("test interrupt done");
    wr(IDX_DC1, 8'h00);
    wr(IDX_CTL, 8'h11);
    wr(IDX_DC1, 8'h90);
    pm.access(HIT, 16'h005a, 1'b0, 1'b1);
    #1;
    check("breakpoint", 32'(breakpoint), 32'h1);
    check("trace stop", 32'(trace_stop), 32'h1);
    check("armed", 32'(armed), 32'h0);
    wr(IDX_DC1, 8'h80);
    pm.access(HIT, 16'h005a, 1'b0, 1'b1);
    #1;
    check("no breakpoint", 32'(breakpoint), 32'h0);
    check("trace stop", 32'(trace_stop), 32'h1);
    rdchk("status end", IDX_IST, 8'h09);
    wr(IDX_DC1, 8'h02);
    wr(IDX_CTL, 8'h01);
    wr(IDX_DC1, 8'h82);
    pm.access(18'h30000, 16'h0000, 1'b0, 1'b0);
    #1;
    check("match c", 32'(seq_match), 32'h4);
    $display("test session end done");
    final_report();
  end
endmodule : test_cmp_match
